/* design/fbp_regs.vh */
`ifndef FBP_REGS_VH
`define FBP_REGS_VH

// Array geometry
`define FBP_ADDR_W 17
`define FBP_FLASH_BYTES 131072
`define FBP_BLK_W 7
`define FBP_BLK_LSB 10
`define FBP_UNIT_W 6
`define FBP_UNIT_LSB 11
`define FBP_UNITS 64
`define FBP_DATA_W 32

// Read requester kinds
`define FBP_KIND_FETCH 2'h0
`define FBP_KIND_DATA 2'h1
`define FBP_KIND_DEBUG 2'h2

// Values
`define FBP_ERASED_WORD 32'hffffffff
`define FBP_DENIED_WORD 32'h00000000

`endif

/* design/fbp_ctrl.v */
`timescale 1ns/1ps
`include "fbp_regs.vh"

module fbp_ctrl #(
  parameter UNITS = `FBP_UNITS
) (
  input wire clk_i, // System clock
  input wire rst_i, // Synchronous reset, active high
  input wire rd_req_i, // Read request strobe
  input wire [1:0] rd_kind_i, // Fetch, data or debug read
  input wire [`FBP_ADDR_W-1:0] rd_addr_i, // Read byte address
  output reg rd_valid_o, // Read answer pulse
  output reg rd_err_o, // Read denied, with rd_valid_o
  output reg [`FBP_DATA_W-1:0] rd_data_o, // Read data
  input wire er_req_i, // Erase request strobe
  input wire [`FBP_BLK_W-1:0] er_blk_i, // Erase block index
  input wire pg_req_i, // Program request strobe
  input wire [`FBP_ADDR_W-1:0] pg_addr_i, // Program byte address
  input wire [`FBP_DATA_W-1:0] pg_data_i, // Program word
  output reg wr_done_o, // Erase or program accepted pulse
  output reg wr_err_o, // Erase or program refused pulse
  input wire [UNITS-1:0] ro_i, // Read-only mark per pair
  input wire [UNITS-1:0] xo_i, // Execute-only mark per pair
  output reg viol_o, // Sticky protection violation
  input wire viol_clr_i, // Clear violation flag
  input wire [`FBP_DATA_W-1:0] arr_rdata_i, // Array word at rd_addr_i
  output reg arr_erase_o, // Erase command pulse to array
  output reg [`FBP_BLK_W-1:0] arr_erase_blk_o, // Block to erase
  output reg arr_prog_o, // Program command pulse to array
  output reg [`FBP_ADDR_W-1:0] arr_prog_addr_o, // Program address
  output reg [`FBP_DATA_W-1:0] arr_prog_data_o // Program word
);

  localparam UNIT_W = `FBP_UNIT_W;
  localparam BLK_W = `FBP_BLK_W;
  localparam ADDR_W = `FBP_ADDR_W;
  localparam DATA_W = `FBP_DATA_W;

  function [UNIT_W-1:0] unit_of;
    input [ADDR_W-1:0] a;
    begin
      unit_of = a[ADDR_W-1:`FBP_UNIT_LSB];
    end
  endfunction

  function [UNIT_W-1:0] unit_of_blk;
    input [BLK_W-1:0] b;
    begin
      unit_of_blk = b[BLK_W-1:1];
    end
  endfunction

  // Unused kind code counts as non-fetch
  function is_fetch;
    input [1:0] k;
    begin
      case (k)
        `FBP_KIND_FETCH: is_fetch = 1'b1;
        `FBP_KIND_DATA: is_fetch = 1'b0;
        `FBP_KIND_DEBUG: is_fetch = 1'b0;
        default: is_fetch = 1'b0;
      endcase
    end
  endfunction

  wire [UNIT_W-1:0] rd_unit;
  wire [UNIT_W-1:0] er_unit;
  wire [UNIT_W-1:0] pg_unit;
  wire [UNITS-1:0] lock_vec;
  wire [UNITS-1:0] rd_hit;
  wire [UNITS-1:0] er_hit;
  wire [UNITS-1:0] pg_hit;
  wire rd_xo;
  wire er_lock;
  wire pg_lock;
  wire kind_fetch;
  wire kind_data;
  wire kind_debug;
  wire kind_other;
  wire rd_deny;
  wire er_take;
  wire er_deny;
  wire pg_take;
  wire pg_deny;
  wire any_deny;

  assign rd_unit = unit_of(rd_addr_i);
  assign er_unit = unit_of_blk(er_blk_i);
  assign pg_unit = unit_of(pg_addr_i);

  genvar gi;
  generate
    for (gi = 0; gi < UNITS; gi = gi + 1) begin : g_unit
      localparam [UNIT_W-1:0] IDX = gi;
      assign lock_vec[gi] = ro_i[gi] | xo_i[gi];
      assign rd_hit[gi] = (rd_unit == IDX);
      assign er_hit[gi] = (er_unit == IDX);
      assign pg_hit[gi] = (pg_unit == IDX);
    end
  endgenerate

  // Marks of the addressed pair only
  assign rd_xo = |(rd_hit & xo_i);
  assign er_lock = |(er_hit & lock_vec);
  assign pg_lock = |(pg_hit & lock_vec);

  assign kind_fetch = is_fetch(rd_kind_i);
  assign kind_data = (rd_kind_i == `FBP_KIND_DATA);
  assign kind_debug = (rd_kind_i == `FBP_KIND_DEBUG);
  // Reserved kind code gets no fetch rights
  assign kind_other = ~kind_fetch & ~kind_data & ~kind_debug;

  assign rd_deny = rd_req_i & rd_xo & (kind_data | kind_debug | kind_other);
  assign er_take = er_req_i;
  assign er_deny = er_take & er_lock;
  // Erase wins over a program in the same cycle; the program is dropped
  assign pg_take = pg_req_i & ~er_req_i;
  assign pg_deny = pg_take & pg_lock;
  assign any_deny = rd_deny | er_deny | pg_deny;

  reg rd_valid_next;
  reg rd_err_next;
  reg [DATA_W-1:0] rd_data_next;
  reg arr_erase_next;
  reg [BLK_W-1:0] arr_erase_blk_next;
  reg arr_prog_next;
  reg [ADDR_W-1:0] arr_prog_addr_next;
  reg [DATA_W-1:0] arr_prog_data_next;
  reg wr_done_next;
  reg wr_err_next;
  reg viol_next;

  always @* begin
    rd_valid_next = rd_req_i;
    rd_err_next = rd_deny;
    rd_data_next = rd_data_o;
    if (rd_req_i) begin
      if (rd_deny) begin
        rd_data_next = `FBP_DENIED_WORD;
      end else begin
        rd_data_next = arr_rdata_i;
      end
    end
  end

  always @* begin
    arr_erase_next = er_take & ~er_deny;
    arr_erase_blk_next = arr_erase_blk_o;
    if (er_take) begin
      arr_erase_blk_next = er_blk_i;
    end
  end

  always @* begin
    arr_prog_next = pg_take & ~pg_deny;
    arr_prog_addr_next = arr_prog_addr_o;
    arr_prog_data_next = arr_prog_data_o;
    if (pg_take) begin
      arr_prog_addr_next = pg_addr_i;
      arr_prog_data_next = pg_data_i;
    end
  end

  always @* begin
    wr_done_next = 1'b0;
    wr_err_next = 1'b0;
    if (er_take) begin
      wr_done_next = ~er_deny;
      wr_err_next = er_deny;
    end else if (pg_take) begin
      wr_done_next = ~pg_deny;
      wr_err_next = pg_deny;
    end
  end

  always @* begin
    viol_next = viol_o;
    if (any_deny) begin
      viol_next = 1'b1;
    end else if (viol_clr_i) begin
      viol_next = 1'b0;
    end
  end

  // Registered answer one edge after request
  always @(posedge clk_i) begin
    if (rst_i) begin
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= rd_valid_next;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      rd_err_o <= 1'b0;
    end else begin
      rd_err_o <= rd_err_next;
    end
  end

  // Data holds between reads for slow consumers
  always @(posedge clk_i) begin
    if (rst_i) begin
      rd_data_o <= `FBP_DENIED_WORD;
    end else begin
      rd_data_o <= rd_data_next;
    end
  end

  // Array fills the erased block with ones
  always @(posedge clk_i) begin
    if (rst_i) begin
      arr_erase_o <= 1'b0;
    end else begin
      arr_erase_o <= arr_erase_next;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      arr_erase_blk_o <= {BLK_W{1'b0}};
    end else begin
      arr_erase_blk_o <= arr_erase_blk_next;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      arr_prog_o <= 1'b0;
    end else begin
      arr_prog_o <= arr_prog_next;
    end
  end

  // Address and word stay put after the pulse
  always @(posedge clk_i) begin
    if (rst_i) begin
      arr_prog_addr_o <= {ADDR_W{1'b0}};
    end else begin
      arr_prog_addr_o <= arr_prog_addr_next;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      arr_prog_data_o <= `FBP_ERASED_WORD;
    end else begin
      arr_prog_data_o <= arr_prog_data_next;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wr_done_o <= 1'b0;
    end else begin
      wr_done_o <= wr_done_next;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wr_err_o <= 1'b0;
    end else begin
      wr_err_o <= wr_err_next;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      viol_o <= 1'b0;
    end else begin
      viol_o <= viol_next;
    end
  end

endmodule // fbp_ctrl

/* tb/fbp_ctrl_monitor.sv */
`timescale 1ns/1ps
module fbp_mon #(parameter UNITS = 64) (
  input wire clk_i, rst_i, rd_req_i, er_req_i, pg_req_i, rd_valid_o, rd_err_o, wr_err_o, viol_o, arr_erase_o,
  input wire arr_prog_o, input wire [1:0] rd_kind_i, input wire [6:0] er_blk_i, arr_erase_blk_o,
  input wire [16:0] rd_addr_i, pg_addr_i, input wire [31:0] rd_data_o, arr_rdata_i,
  input wire [UNITS-1:0] ro_i, xo_i);
  // Protection marks of the addressed pair
  wire xr = xo_i[rd_addr_i[16:11]];
  wire pe = ro_i[er_blk_i[6:1]] | xo_i[er_blk_i[6:1]];
  wire pp = ro_i[pg_addr_i[16:11]] | xo_i[pg_addr_i[16:11]];
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_rd_answer: assert property (rd_req_i |=> rd_valid_o) else $error("read late");
  a_fetch_ok: assert property (rd_req_i && !rd_kind_i |=> rd_data_o == $past(arr_rdata_i)) else $error("fetch");
  a_xo_deny: assert property (rd_req_i && rd_kind_i && xr |=> rd_err_o && !rd_data_o) else $error("leak");
  a_ro_read: assert property (rd_req_i && !xr |=> !rd_err_o) else $error("denied");
  a_er_deny: assert property (er_req_i && pe |=> wr_err_o && !arr_erase_o) else $error("erase");
  a_er_block: assert property (er_req_i && !pe |=> arr_erase_blk_o == $past(er_blk_i)) else $error("block");
  a_pg_deny: assert property (pg_req_i && !er_req_i && pp |=> wr_err_o && !arr_prog_o) else $error("prog");
  a_viol_set: assert property (wr_err_o || rd_err_o |-> viol_o) else $error("flag");
endmodule // fbp_mon
bind fbp_ctrl fbp_mon #(.UNITS(UNITS)) u_fbp_mon (.clk_i(clk_i), .rst_i(rst_i), .rd_req_i(rd_req_i),
  .er_req_i(er_req_i), .pg_req_i(pg_req_i), .rd_valid_o(rd_valid_o), .rd_err_o(rd_err_o), .wr_err_o(wr_err_o),
  .viol_o(viol_o), .arr_erase_o(arr_erase_o), .arr_prog_o(arr_prog_o), .rd_kind_i(rd_kind_i), .er_blk_i(er_blk_i),
  .arr_erase_blk_o(arr_erase_blk_o), .rd_addr_i(rd_addr_i), .pg_addr_i(pg_addr_i), .rd_data_o(rd_data_o),
  .arr_rdata_i(arr_rdata_i), .ro_i(ro_i), .xo_i(xo_i));

/* tb/fbp_flash_model.sv */
`timescale 1ns/1ps
module fbp_flash_model (input wire clk_i, arr_erase_o, arr_prog_o, input wire [6:0] arr_erase_blk_o,
  input wire [16:0] rd_addr_i, arr_prog_addr_o, input wire [31:0] arr_prog_data_o, output wire [31:0] arr_rdata_i);
  reg [31:0] mem [0:32767];
  integer i;
  // Combinational read, same cycle as the request
  assign arr_rdata_i = mem[rd_addr_i[16:2]];
  always @(posedge clk_i) begin
    if (arr_erase_o) for (i = 0; i < 256; i = i + 1) mem[{arr_erase_blk_o, i[7:0]}] <= 32'hffffffff;
    if (arr_prog_o) mem[arr_prog_addr_o[16:2]] <= arr_prog_data_o;
  end
endmodule // fbp_flash_model

/* tb/flash_block_protection_tb_top.sv */
`timescale 1ns/1ps
module flash_block_protection_tb_top;
  reg clk_i = 0, rst_i = 1, rd_req_i = 0, er_req_i = 0, pg_req_i = 0, viol_clr_i = 0;
  reg [1:0] rd_kind_i = 0;
  reg [6:0] er_blk_i = 0;
  reg [16:0] rd_addr_i = 0, pg_addr_i = 0;
  reg [31:0] pg_data_i = 0;
  reg [63:0] ro_i = 0, xo_i = 0;
  wire rd_valid_o, rd_err_o, wr_done_o, wr_err_o, viol_o, arr_erase_o, arr_prog_o;
  wire [6:0] arr_erase_blk_o;
  wire [16:0] arr_prog_addr_o;
  wire [31:0] rd_data_o, arr_rdata_i, arr_prog_data_o;
  integer n_errors = 0, checks_done = 0;
  fbp_ctrl u_fbp_ctrl (.clk_i(clk_i), .rst_i(rst_i), .rd_req_i(rd_req_i), .rd_kind_i(rd_kind_i),
    .rd_addr_i(rd_addr_i), .rd_valid_o(rd_valid_o), .rd_err_o(rd_err_o), .rd_data_o(rd_data_o), .er_req_i(er_req_i),
    .er_blk_i(er_blk_i), .pg_req_i(pg_req_i), .pg_addr_i(pg_addr_i), .pg_data_i(pg_data_i), .wr_done_o(wr_done_o),
    .wr_err_o(wr_err_o), .ro_i(ro_i), .xo_i(xo_i), .viol_o(viol_o), .viol_clr_i(viol_clr_i),
    .arr_rdata_i(arr_rdata_i), .arr_erase_o(arr_erase_o), .arr_erase_blk_o(arr_erase_blk_o),
    .arr_prog_o(arr_prog_o), .arr_prog_addr_o(arr_prog_addr_o), .arr_prog_data_o(arr_prog_data_o));
  fbp_flash_model u_fbp_flash_model (.clk_i(clk_i), .arr_erase_o(arr_erase_o), .arr_prog_o(arr_prog_o),
    .arr_erase_blk_o(arr_erase_blk_o), .rd_addr_i(rd_addr_i), .arr_prog_addr_o(arr_prog_addr_o),
    .arr_prog_data_o(arr_prog_data_o), .arr_rdata_i(arr_rdata_i));
  initial forever #5 clk_i = ~clk_i;
  task chk(input [33:0] seen, exp);
    checks_done = checks_done + 1;
    if (seen !== exp) n_errors = n_errors + 1;
    if (seen !== exp) $display("Error at %0t: seen %h expected %h", $time, seen, exp);
  endtask
  task finish_test;
    if (n_errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task rd(input [1:0] k, input [16:0] a, input [31:0] d, input e);
    @(negedge clk_i) {rd_req_i, rd_kind_i, rd_addr_i} = {1'h1, k, a};
    @(negedge clk_i) rd_req_i = 0;
    chk({rd_valid_o, rd_err_o, rd_data_o}, {1'h1, e, d});
  endtask
  task wr(input r, input [16:0] a, input [31:0] d, input e);
    @(negedge clk_i) {er_req_i, pg_req_i, er_blk_i, pg_addr_i, pg_data_i} = {r, !r, a[16:10], a, d};
    @(negedge clk_i) {er_req_i, pg_req_i} = 2'h0;
    chk({wr_done_o, wr_err_o, arr_erase_o | arr_prog_o}, {!e, e, !e});
  endtask
  task t_erase_prog;
    wr(1'h1, 17'h1400, 32'h0, 1'h0);
    wr(1'h0, 17'h1404, 32'h5a5a0f0f, 1'h0);
    rd(2'h2, 17'h1400, 32'hffffffff, 1'h0);
    wr(1'h1, 17'h1fc00, 32'h0, 1'h0);
    rd(2'h1, 17'h1fffc, 32'hffffffff, 1'h0);
  endtask
  task t_protect;
    ro_i[2] = 1'h1;
    wr(1'h1, 17'h1000, 32'h0, 1'h1);
    rd(2'h1, 17'h1404, 32'h5a5a0f0f, 1'h0);
    {ro_i[2], xo_i[2], viol_clr_i} = 3'h3;
    rd(2'h0, 17'h1404, 32'h5a5a0f0f, 1'h0);
    viol_clr_i = 0;
    chk(viol_o, 1'h0);
    rd(2'h2, 17'h1000, 32'h0, 1'h1);
    rd(2'h3, 17'h1000, 32'h0, 1'h1);
    wr(1'h0, 17'h1404, 32'h0, 1'h1);
    chk(viol_o, 1'h1);
  endtask
  initial begin
    repeat (8) @(negedge clk_i);
    rst_i = 0;
    t_erase_prog;
    t_protect;
    finish_test;
  end
endmodule // flash_block_protection_tb_top
